// *** shared/dsc_consts.svh ***
`ifndef DSC_CONSTS_SVH
`define DSC_CONSTS_SVH
// ==========================================================
// bus map (byte addresses)
`define DSC_ADDR_INWORD       8'h40
`define DSC_ADDR_LOAD         8'h44
`define DSC_ADDR_STATUS       8'h48
// ==========================================================
// destination indices carried in control word bits [2:0]
`define DSC_IDX_RF_N          3'h0
`define DSC_IDX_RF_REF        3'h1
`define DSC_IDX_RF_CTRL       3'h2
`define DSC_IDX_MASTER        3'h3
`define DSC_IDX_IF_N          3'h4
`define DSC_IDX_IF_REF        3'h5
`define DSC_IDX_IF_CTRL       3'h6
// ==========================================================
// rf_reference_and_modulus fields
`define DSC_RF_R_LSB          3
`define DSC_RF_R_MSB          6
`define DSC_MOD_LSB           7
`define DSC_MOD_MSB           18
// rf_control fields
`define DSC_RFC_CNT_RST       3
`define DSC_RFC_TRI           4
`define DSC_RFC_PD            5
`define DSC_RFC_NS0           6
`define DSC_RFC_POL           7
`define DSC_RFC_NS1           11
`define DSC_RFC_NS2           15
`define DSC_RFC_CP_LSB        9
`define DSC_RFC_CP_MSB        10
`define DSC_RFC_TEST_LSB      12
`define DSC_RFC_TEST_MSB      14
// master_control fields
`define DSC_MST_CNT_RST       3
`define DSC_MST_TRI           4
`define DSC_MST_PD            5
`define DSC_MST_XO_DIS        6
`define DSC_MST_MUX_LSB       7
`define DSC_MST_MUX_MSB       10
// if_feedback_divider / if_reference_divider fields
`define DSC_IFN_BOOST         23
`define DSC_IFR_R_LSB         3
`define DSC_IFR_R_MSB         17
`define DSC_IFR_DOUBLER       18
// ==========================================================
// noise and spur codes
`define DSC_NS_LOW_SPUR       3'h0
`define DSC_NS_LOW_BOTH       3'h1
`define DSC_NS_LOW_NOISE      3'h7
// lock detect: good cycles needed, comparator thresholds in ns
`define DSC_LOCK_COUNT        6'd40
`define DSC_LOCK_ERR_LOW_NS   15
`define DSC_LOCK_ERR_HIGH_NS  30
// reset value of every stored word
`define DSC_WORD_RESET        24'h00_0000
`endif

// *** shared/dsc_pkg.sv ***
`default_nettype none
package dsc_pkg;
   // phase comparator flags of one section, sampled on its pfd tick
   typedef struct packed {
      logic err_below_low;   // error under the lock threshold
      logic err_above_high;  // error over the unlock threshold
   } dsc_phase_err_t;

   // software-visible state
   typedef struct packed {
      logic if_held;
      logic rf_held;
      logic power_down;
      logic mux_valid;
      logic if_lock;
      logic rf_lock;
   } dsc_status_t;

   // decoded rf loop settings
   typedef struct packed {
      logic       dither_enable;
      logic       pump_optimum;
      logic       pfd_polarity;
      logic [1:0] pump_current;
   } dsc_rf_cfg_t;
endpackage
`default_nettype wire

// *** logic/dsc_control.sv ***
// Summary of operation
// - rf reference divides by 1 to 15
// - twelve bit fractional modulus field held
// - codes 010, 011 load rf control, master
// - codes 100, 101 load if dividers
// - noise field selects dither and pump mode
// - rf counter reset bit holds rf counters
// - rf power-down: load state, tristate, unlock
// - two bits select rf pump current
// - master reset holds all counters, aligned restart
// - master tristate floats both charge pumps
// - master power-down stops counters, buffer, lock
// - oscillator disable turns reference output off
// - master bits 10..7 select mux output
// - control writes lose mux selection
// - lock after 40 good cycles, clear on large error
// - if boost forces maximum pump current
// - if doubler counts both reference edges
// - if reference divides by 1 to 32767
// - code 001 loads rf reference and modulus
`include "dsc_consts.svh"
`default_nettype none
module dsc_control (
   input  wire logic                  core_clk,
   input  wire logic                  reset,
   input  wire logic [7:0]            avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [31:0]           avs_writedata,
   output logic      [31:0]           avs_readdata,
   output logic                       avs_waitrequest,
   input  wire logic                  reference_input,
   input  wire dsc_pkg::dsc_phase_err_t rf_phase_err,
   input  wire dsc_pkg::dsc_phase_err_t if_phase_err,
   output logic                       rf_pfd_ref_tick,
   output logic                       if_pfd_ref_tick,
   output dsc_pkg::dsc_rf_cfg_t       rf_cfg,
   output logic [11:0]                fractional_modulus,
   output logic                       rf_counter_hold,
   output logic                       if_counter_hold,
   output logic                       rf_pump_tristate,
   output logic                       if_pump_tristate,
   output logic                       if_pump_force_max,
   output logic                       osc_buffer_enable,
   output logic                       reference_output_enable,
   output logic                       mux_output_pin
);
   // ==========================================================
   // bus slave: one wait cycle, answer on the second edge
   logic        ack;
   logic        bus_req;
   logic        wr_take;
   logic [23:0] in_word;
   logic [23:0] bank [0:7];
   logic        load_pulse;
   logic [2:0]  load_idx;
   dsc_pkg::dsc_status_t status;

   assign bus_req         = avs_read | avs_write;
   assign avs_waitrequest = bus_req & ~ack;
   assign wr_take         = avs_write & ack;

   // ack toggles so every request sees exactly one wait cycle
   always_ff @(posedge core_clk) begin
      if (reset) begin
         ack <= 1'b0;
      end else begin
         ack <= bus_req & ~ack;
      end
   end

   // read data captured in the wait cycle, stable at the answer edge
   always_ff @(posedge core_clk) begin
      if (reset) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read & ~ack) begin
         case (avs_address)
            `DSC_ADDR_INWORD: avs_readdata <= {8'h00, in_word};
            `DSC_ADDR_STATUS: avs_readdata <= {26'h000_0000, status};
            {3'h0, `DSC_IDX_RF_REF, 2'h0},
            {3'h0, `DSC_IDX_RF_CTRL, 2'h0},
            {3'h0, `DSC_IDX_MASTER, 2'h0},
            {3'h0, `DSC_IDX_IF_N, 2'h0},
            {3'h0, `DSC_IDX_IF_REF, 2'h0}: avs_readdata <= {8'h00, bank[avs_address[4:2]]};
            default: avs_readdata <= 32'h0000_0000; // unmapped reads zero
         endcase
      end
   end

   // ==========================================================
   // input register and load strobe
   // input register stays writable even in power-down
   always_ff @(posedge core_clk) begin
      if (reset) begin
         in_word <= `DSC_WORD_RESET;
      end else if (wr_take && avs_address == `DSC_ADDR_INWORD) begin
         in_word <= avs_writedata[23:0];
      end
   end

   assign load_pulse = wr_take && avs_address == `DSC_ADDR_LOAD;
   assign load_idx   = in_word[2:0];

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_bank
         always_ff @(posedge core_clk) begin
            if (reset) begin
               bank[gi] <= `DSC_WORD_RESET;
            end else if (load_pulse && load_idx == 3'(gi)) begin
               bank[gi] <= in_word;
            end
         end
      end
   endgenerate

   // ==========================================================
   // decoded controls
   logic [23:0] rf_ref_w;
   logic [23:0] rf_ctl_w;
   logic [23:0] mst_w;
   logic [23:0] ifn_w;
   logic [23:0] ifr_w;
   logic        rf_pd;
   logic        mst_pd;
   logic [2:0]  noise_code;

   assign rf_ref_w = bank[`DSC_IDX_RF_REF];
   assign rf_ctl_w = bank[`DSC_IDX_RF_CTRL];
   assign mst_w    = bank[`DSC_IDX_MASTER];
   assign ifn_w    = bank[`DSC_IDX_IF_N];
   assign ifr_w    = bank[`DSC_IDX_IF_REF];
   assign rf_pd    = rf_ctl_w[`DSC_RFC_PD];
   assign mst_pd   = mst_w[`DSC_MST_PD];

   assign fractional_modulus = rf_ref_w[`DSC_MOD_MSB:`DSC_MOD_LSB];

   assign noise_code = {rf_ctl_w[`DSC_RFC_NS2], rf_ctl_w[`DSC_RFC_NS1], rf_ctl_w[`DSC_RFC_NS0]};
   always_ff @(posedge core_clk) begin
      if (reset) begin
         rf_cfg <= '0;
      end else begin
         rf_cfg.dither_enable <= (noise_code == `DSC_NS_LOW_SPUR);
         rf_cfg.pump_optimum  <= (noise_code == `DSC_NS_LOW_NOISE);
         rf_cfg.pfd_polarity  <= rf_ctl_w[`DSC_RFC_POL];  // host picks slope
         rf_cfg.pump_current  <= rf_ctl_w[`DSC_RFC_CP_MSB:`DSC_RFC_CP_LSB];
      end
   end

   // counters held or loaded
   // rf power-down also stops the if section
   always_ff @(posedge core_clk) begin
      if (reset) begin
         rf_counter_hold <= 1'b1;
         if_counter_hold <= 1'b1;
      end else begin
         rf_counter_hold <= rf_ctl_w[`DSC_RFC_CNT_RST] | mst_w[`DSC_MST_CNT_RST]
                            | rf_pd | mst_pd;
         if_counter_hold <= mst_w[`DSC_MST_CNT_RST] | rf_pd | mst_pd;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         rf_pump_tristate <= 1'b1;
         if_pump_tristate <= 1'b1;
      end else begin
         rf_pump_tristate <= rf_ctl_w[`DSC_RFC_TRI] | mst_w[`DSC_MST_TRI] | rf_pd | mst_pd;
         if_pump_tristate <= mst_w[`DSC_MST_TRI] | rf_pd | mst_pd;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         osc_buffer_enable       <= 1'b0;
         reference_output_enable <= 1'b0;
         if_pump_force_max       <= 1'b0;
      end else begin
         osc_buffer_enable       <= ~mst_pd;
         reference_output_enable <= ~mst_w[`DSC_MST_XO_DIS];
         if_pump_force_max       <= ifn_w[`DSC_IFN_BOOST]; // clearing restores setting
      end
   end

   // ==========================================================
   // reference pin: three flops, level moves when 2nd and 3rd agree
   logic [2:0] ref_sync;
   logic       ref_level;
   logic       ref_rise;
   logic       ref_fall;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         ref_sync  <= 3'h0;
         ref_level <= 1'b0;
      end else begin
         ref_sync <= {ref_sync[1:0], reference_input};
         if (ref_sync[1] == ref_sync[2]) begin
            ref_level <= ref_sync[2];
         end
      end
   end
   assign ref_rise = (ref_sync[1] == ref_sync[2]) &  ref_sync[2] & ~ref_level;
   assign ref_fall = (ref_sync[1] == ref_sync[2]) & ~ref_sync[2] &  ref_level;

   // ==========================================================
   // reference dividers; held counters restart together from zero
   logic [3:0]  rf_rcnt;
   logic [3:0]  rf_ratio;
   logic [14:0] if_rcnt;
   logic [14:0] if_ratio;
   logic        if_edge;
   logic        rf_wrap;
   logic        if_wrap;

   // ratio zero is treated as one
   assign rf_ratio = (rf_ref_w[`DSC_RF_R_MSB:`DSC_RF_R_LSB] == 4'h0) ? 4'h1
                     : rf_ref_w[`DSC_RF_R_MSB:`DSC_RF_R_LSB];
   assign if_ratio = (ifr_w[`DSC_IFR_R_MSB:`DSC_IFR_R_LSB] == 15'h0000) ? 15'h0001
                     : ifr_w[`DSC_IFR_R_MSB:`DSC_IFR_R_LSB];
   assign if_edge  = ifr_w[`DSC_IFR_DOUBLER] ? (ref_rise | ref_fall) : ref_rise;
   assign rf_wrap  = (rf_rcnt == rf_ratio - 4'h1);
   assign if_wrap  = (if_rcnt == if_ratio - 15'h0001);

   always_ff @(posedge core_clk) begin
      if (reset || rf_counter_hold) begin
         rf_rcnt         <= 4'h0;
         rf_pfd_ref_tick <= 1'b0;
      end else begin
         rf_pfd_ref_tick <= ref_rise & rf_wrap;
         if (ref_rise) begin
            rf_rcnt <= rf_wrap ? 4'h0 : rf_rcnt + 4'h1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset || if_counter_hold) begin
         if_rcnt         <= 15'h0000;
         if_pfd_ref_tick <= 1'b0;
      end else begin
         if_pfd_ref_tick <= if_edge & if_wrap;
         if (if_edge) begin
            if_rcnt <= if_wrap ? 15'h0000 : if_rcnt + 15'h0001;
         end
      end
   end

   // ==========================================================
   // digital lock detect, one per section
   logic [1:0]                    lock;
   logic [1:0]                    lock_tick;
   logic [1:0]                    lock_clear;
   dsc_pkg::dsc_phase_err_t [1:0] lock_err;
   logic [5:0]                    good_cnt [0:1];

   assign lock_tick     = {if_pfd_ref_tick, rf_pfd_ref_tick};
   assign lock_err      = {if_phase_err, rf_phase_err};
   // new channel: any word to the section's divider registers
   assign lock_clear[0] = rf_counter_hold
                          | (load_pulse && load_idx == `DSC_IDX_RF_N)
                          | (load_pulse && load_idx == `DSC_IDX_RF_REF);
   assign lock_clear[1] = if_counter_hold
                          | (load_pulse && load_idx == `DSC_IDX_IF_N)
                          | (load_pulse && load_idx == `DSC_IDX_IF_REF);

   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_lock
         // count good cycles, drop on large error
         always_ff @(posedge core_clk) begin
            if (reset || lock_clear[gi]) begin
               good_cnt[gi] <= 6'd0;
               lock[gi]     <= 1'b0;
            end else if (lock_tick[gi]) begin
               if (lock_err[gi].err_above_high) begin
                  good_cnt[gi] <= 6'd0;
                  lock[gi]     <= 1'b0;
               end else if (!lock_err[gi].err_below_low) begin
                  good_cnt[gi] <= 6'd0;   // a middling error keeps lock, breaks the run
               end else if (good_cnt[gi] != `DSC_LOCK_COUNT) begin
                  good_cnt[gi] <= good_cnt[gi] + 6'd1;
                  if (good_cnt[gi] == `DSC_LOCK_COUNT - 6'd1) begin
                     lock[gi] <= 1'b1;
                  end
               end
            end
         end
      end
   endgenerate

   // ==========================================================
   // output multiplexer
   logic       mux_valid;
   logic [3:0] mux_sel;
   logic       next_mux_out;

   // control writes invalidate; master write restores
   always_ff @(posedge core_clk) begin
      if (reset) begin
         mux_valid <= 1'b0;
      end else if (load_pulse && load_idx == `DSC_IDX_MASTER) begin
         mux_valid <= 1'b1;
      end else if (load_pulse && (load_idx == `DSC_IDX_RF_CTRL
                                  || load_idx == `DSC_IDX_IF_CTRL)) begin
         mux_valid <= 1'b0;
      end
   end

   assign mux_sel = mst_w[`DSC_MST_MUX_MSB:`DSC_MST_MUX_LSB];
   always_comb begin
      case (mux_sel)
         4'h1:    next_mux_out = lock[0];
         4'h2:    next_mux_out = lock[1];
         4'h3:    next_mux_out = lock[0] & lock[1];
         4'h4:    next_mux_out = rf_pfd_ref_tick;
         4'h5:    next_mux_out = if_pfd_ref_tick;
         4'h6:    next_mux_out = ref_level;
         4'h7:    next_mux_out = 1'b1;
         default: next_mux_out = 1'b0;
      endcase
   end

   // a lost selection drives low rather than a stale source
   always_ff @(posedge core_clk) begin
      if (reset) begin
         mux_output_pin <= 1'b0;
      end else begin
         mux_output_pin <= mux_valid & next_mux_out;
      end
   end

   assign status = '{if_held: if_counter_hold, rf_held: rf_counter_hold,
                     power_down: rf_pd | mst_pd, mux_valid: mux_valid,
                     if_lock: lock[1], rf_lock: lock[0]};

   // ==========================================================
   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   a_load_rf_ctrl: assert property (
      load_pulse && load_idx == `DSC_IDX_RF_CTRL |=> bank[2] == $past(in_word))
      else $error("rf control not loaded");
   a_load_if_ref: assert property (
      load_pulse && load_idx == `DSC_IDX_IF_REF |=> ifr_w == $past(in_word))
      else $error("if reference divider not loaded");
   a_no_strobe_hold: assert property (
      !load_pulse |=> $stable(bank[3]) && $stable(bank[1]))
      else $error("bank changed without strobe");
   a_rf_held_count: assert property (
      rf_ctl_w[`DSC_RFC_CNT_RST] |=> rf_counter_hold ##1 rf_rcnt == 4'h0)
      else $error("rf counter not held");
   a_pd_tristate: assert property (
      rf_pd |=> rf_pump_tristate && if_pump_tristate ##1 !lock[0])
      else $error("power-down incomplete");
   a_master_tri: assert property (
      mst_w[`DSC_MST_TRI] |=> rf_pump_tristate && if_pump_tristate)
      else $error("master tristate ignored");
   a_master_pd: assert property (
      mst_pd |=> !osc_buffer_enable ##1 (!lock[0] && !lock[1]))
      else $error("master power-down incomplete");
   a_mux_lost: assert property (
      load_pulse && load_idx == `DSC_IDX_RF_CTRL |=> ##1 !mux_output_pin)
      else $error("mux selection survived control write");
   a_rf_div_ratio: assert property (
      rf_pfd_ref_tick && !rf_counter_hold && $stable(rf_ratio)
      |-> ##1 rf_rcnt == 4'h0)
      else $error("rf reference wrap wrong");
   a_lock_drop: assert property (
      lock_tick[0] && lock_err[0].err_above_high |=> !lock[0])
      else $error("lock kept after large error");
   a_lock_rise: assert property (
      $rose(lock[0]) |-> $past(good_cnt[0]) == `DSC_LOCK_COUNT - 6'd1)
      else $error("lock rose early");
   a_boost: assert property (
      ifn_w[`DSC_IFN_BOOST] |=> if_pump_force_max)
      else $error("boost not applied");

   c_rf_lock:   cover property ($rose(lock[0]));
   c_mux_lost:  cover property (mux_valid ##1 !mux_valid);
   c_doubled:   cover property (ifr_w[`DSC_IFR_DOUBLER] && if_pfd_ref_tick);
   c_pd_resume: cover property ($fell(rf_counter_hold) ##[1:200] rf_pfd_ref_tick);
endmodule
`default_nettype wire

// *** testbench/dsc_far_model.sv ***
`default_nettype none
module dsc_far_model (
   input  wire logic               core_clk,
   input  wire logic               reset,
   input  wire logic [1:0]         err_mode,
   output logic                    reference_input,
   output dsc_pkg::dsc_phase_err_t rf_phase_err,
   output dsc_pkg::dsc_phase_err_t if_phase_err
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] phase;
   // reference source, eight core cycles a period; runs free like a crystal
   always_ff @(posedge core_clk) begin
      if (reset) begin
         phase <= 2'h0;
         reference_input <= 1'b0;
      end else begin
         phase <= phase + 2'h1;
         if (phase == 2'h3) begin
            reference_input <= ~reference_input;
         end
      end
   end
   // comparator flags
   // mode 0 under low threshold, 1 between, 2 over high threshold
   always_comb begin
      rf_phase_err = {err_mode == 2'h0, err_mode == 2'h2};
      if_phase_err = rf_phase_err;
   end
endmodule
`default_nettype wire

// *** testbench/dual_synth_control_registers_bench.sv ***
`include "dsc_consts.svh"
`default_nettype none
module dual_synth_control_registers_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        core_clk, reset, avs_read, avs_write, avs_waitrequest;
   logic [7:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic        reference_input, rf_tick, if_tick, rf_hold, if_hold, mux_pin;
   logic        rf_tri, if_tri, force_max, osc_en, reference_output_en;
   logic [1:0]  err_mode;
   logic [11:0] fractional_modulus;
   dsc_pkg::dsc_phase_err_t rf_err, if_err;
   dsc_pkg::dsc_rf_cfg_t    rf_cfg;
   int          fails, samples_checked, n;

   dsc_control dut (.core_clk(core_clk), .reset(reset), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .reference_input(reference_input), .rf_phase_err(rf_err), .if_phase_err(if_err),
      .rf_pfd_ref_tick(rf_tick), .if_pfd_ref_tick(if_tick), .rf_cfg(rf_cfg),
      .fractional_modulus(fractional_modulus), .rf_counter_hold(rf_hold),
      .if_counter_hold(if_hold), .rf_pump_tristate(rf_tri), .if_pump_tristate(if_tri),
      .if_pump_force_max(force_max), .osc_buffer_enable(osc_en),
      .reference_output_enable(reference_output_en), .mux_output_pin(mux_pin));
   dsc_far_model far (.core_clk(core_clk), .reset(reset), .err_mode(err_mode),
      .reference_input(reference_input), .rf_phase_err(rf_err), .if_phase_err(if_err));

   // ==========================================
   // clock, helpers
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // master holds the request until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge core_clk);
      avs_read <= ~wr;
      avs_write <= wr;
      avs_address <= a;
      avs_writedata <= d;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 50);
      if (k >= 50) begin
         fails++;
         $display("[ERR] %0t bus answer missing", $time);
      end
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      check(q, e);
   endtask
   // word then strobe; decoded outputs settle a few edges later
   task automatic load(input logic [23:0] w);
      bus(1'b1, `DSC_ADDR_INWORD, {8'h00, w});
      bus(1'b1, `DSC_ADDR_LOAD, 32'h0000_0000);
      repeat (3) @(posedge core_clk);
   endtask
   // n gets the cycles waited for the next tick
   task automatic tick(input logic rf);
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while ((rf ? rf_tick : if_tick) !== 1'b1 && n < 2000);
      if (n >= 2000) begin
         fails++;
         $display("[ERR] %0t tick missing", $time);
      end
   endtask
   function automatic logic [6:0] outs();
      return {rf_hold, if_hold, rf_tri, if_tri, osc_en, reference_output_en, force_max};
   endfunction

   // ==========================================
   // scenarios
   task automatic t_reset();
      repeat (3) @(posedge core_clk);
      check(outs(), 7'h06);
      rd(`DSC_ADDR_STATUS, 32'h0000_0000);
      rd(8'h30, 32'h0000_0000);
   endtask
   task automatic t_decode();
      logic [23:0] w [5] = '{24'h05_5E09, 24'h00_0082, 24'h00_0383, 24'h00_0004, 24'h00_001D};
      bus(1'b1, `DSC_ADDR_INWORD, 32'h0000_0082);
      repeat (3) @(posedge core_clk);
      rd(8'h08, 32'h0000_0000);
      // first control word keeps bits 15..11 zero
      for (int i = 0; i < 5; i++) load(w[i]);
      for (int i = 0; i < 5; i++) rd(8'((i + 1) * 4), {8'h00, w[i]});
      check(fractional_modulus, 12'hABC);
      check(mux_pin, 1'b1);
      load(24'h00_0082);
      check(mux_pin, 1'b0);
      load(24'h00_0383);
      load(24'h00_0006);
      check(mux_pin, 1'b0);
      load(24'h00_0383);
      check(mux_pin, 1'b1);
   endtask
   task automatic t_noise();
      logic [2:0] c [4] = '{3'h0, 3'h1, 3'h7, 3'h0};
      for (int i = 0; i < 4; i++) begin
         load({8'h00, c[i][2], 3'h0, c[i][1], 2'(i), 1'b0, 1'b1, c[i][0], 6'h02});
         check(rf_cfg, {c[i] == 3'h0, c[i] == 3'h7, 1'b1, 2'(i)});
      end
   endtask
   task automatic t_holds();
      logic [23:0] w [11] = '{24'h00_000A, 24'h00_0012, 24'h00_0022, 24'h00_0002,
         24'h00_000B, 24'h00_0013, 24'h00_0023, 24'h00_0043, 24'h00_0003,
         24'h80_0004, 24'h00_0004};
      logic [6:0] e [11] = '{7'h46, 7'h16, 7'h7E, 7'h06, 7'h66, 7'h1E, 7'h7A,
         7'h04, 7'h06, 7'h07, 7'h06};
      for (int i = 0; i < 11; i++) begin
         load(w[i]);
         check(outs(), e[i]);
         if (i == 2) rd(8'h04, 32'h0005_5E09);
      end
   endtask
   task automatic t_divider();
      load(24'h05_5E79);
      tick(1'b1);
      tick(1'b1);
      check(n, 120);
      tick(1'b0);
      tick(1'b0);
      check(n, 24);
      load(24'h04_001D);
      tick(1'b0);
      tick(1'b0);
      check(n, 12);
   endtask
   task automatic t_lock();
      err_mode <= 2'h1;
      load(24'h05_5E09);
      load(24'h00_0083);
      tick(1'b1);
      err_mode <= 2'h0;
      repeat (39) tick(1'b1);
      repeat (3) @(posedge core_clk);
      check(mux_pin, 1'b0);
      tick(1'b1);
      repeat (3) @(posedge core_clk);
      check(mux_pin, 1'b1);
      rd(`DSC_ADDR_STATUS, 32'h0000_0005);
      err_mode <= 2'h1;
      repeat (2) tick(1'b1);
      repeat (3) @(posedge core_clk);
      check(mux_pin, 1'b1);
      err_mode <= 2'h2;
      tick(1'b1);
      repeat (3) @(posedge core_clk);
      check(mux_pin, 1'b0);
      err_mode <= 2'h0;
      repeat (42) tick(1'b1);
      check(mux_pin, 1'b1);
      load(24'h05_5E09);
      check(mux_pin, 1'b0);
      // if lock on the pin, then both locks, then an unused code
      load(24'h00_0103);
      repeat (45) tick(1'b0);
      check(mux_pin, 1'b1);
      load(24'h00_0183);
      check(mux_pin, 1'b1);
      load(24'h00_0003);
      check(mux_pin, 1'b0);
   endtask

   // ==========================================
   // sequence, verdict, watchdog
   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      fails = 0;
      samples_checked = 0;
      reset = 1'b1;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 8'h00;
      avs_writedata = 32'h0000_0000;
      err_mode = 2'h1;
      repeat (6) @(posedge core_clk);
      reset <= 1'b0;
      t_reset();
      t_decode();
      t_noise();
      t_holds();
      t_divider();
      t_lock();
      complete_run();
   end
   // whole run needs about 2000 cycles; allow far more before calling it hung
   initial begin
      #2000000;
      fails++;
      complete_run();
   end
endmodule
`default_nettype wire
